// ===== design/srs_pkg.sv
// Package for the service-request status byte block
package srs_pkg;
	// ==========================================
	// Status byte bit positions
	localparam int BIT_MEAS_END = 0;
	localparam int BIT_SYNTAX   = 1;
	localparam int BIT_COMP     = 2;
	localparam int BIT_SMOOTH1  = 3;
	localparam int BIT_SMOOTH2  = 4;
	localparam int BIT_ZERO     = 5;
	localparam int BIT_RQS      = 6;
	localparam int BIT_CAL      = 7;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	// Bits whose state feeds the summary bit
	localparam logic [7:0] SUMMARY_MASK = 8'h9F;

	// ==========================================
	// Event strobes from the instrument core
	typedef struct packed {
		logic meas_end;
		logic syntax_err;
		logic comp_hilo;
		logic smooth1_full;
		logic smooth2_full;
		logic cal_enter;
	} srs_set_t;

	// ==========================================
	// Clear strobes from the instrument core and bus interface
	typedef struct packed {
		logic dev_clear;
		logic cmd_clear;
		logic data_sent;
		logic setup_change;
		logic trigger;
		logic remote_cmd;
		logic comp_off;
		logic smooth_off;
		logic smooth_count_change;
		logic disp2_off;
		logic serial_poll;
		logic cal_cancel;
	} srs_clr_t;

	typedef enum logic {
		SRS_POLL_IDLE,
		SRS_POLL_ACTIVE
	} srs_poll_t;
endpackage : srs_pkg

// ===== design/srs_status.sv
// Service-request status byte and request line control
`timescale 1ns/10ps

// Function
// [R1] Power-on, device clear and clear commands wipe the whole byte.
// [R2] Measurement-end bit clears on data sent, setup change or trigger.
// [R3] Syntax-error bit clears at the next remote command.
// [R4] Comparator bit clears on comparator off or serial poll.
// [R5] First smoothing bit clears on smoothing off, poll, setup or count change.
// [R6] Second smoothing bit also clears when the second display turns off.
// [R7] Bit five is zero; summary bit clears when all other bits are zero.
// [R8] Calibration bit clears when calibration mode is cancelled.
// [R9] Measurement end sets byte 65, held until data is sent.
// [R10] Controller serial polls; device answers with the current byte.
// [R11] Undefined code requests service; held until next listener addressing.
// [R12] Simultaneous measurement end and syntax error give 67.
// [R13] Comparator HI or LO gives 69.
// [R14] First smoothing full gives 73.
// [R15] Second smoothing full sets its bit on dual-display parts.
// [R16] Entering calibration mode gives 193.
// [R17] Request-off mode never asserts requests; byte stays readable.
// [R18] Request line follows summary bit while requests are enabled.
module srs_status #(
	parameter bit DUAL_DISPLAY = 1'b1
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             resetn,
	// Events and clears
	input  wire srs_pkg::srs_set_t ev_set,
	input  wire srs_pkg::srs_clr_t ev_clr,
	// Mode: high selects srq_off_mode, low srq_on_event_mode
	input  wire logic             srq_off_mode,
	// Serial poll
	input  wire logic             poll_req,
	output logic                  poll_valid,
	output logic [7:0]            poll_byte,
	// Request line and status
	output logic                  srq_out,
	output logic                  srq_oe,
	output logic [7:0]            status_byte
);

	// ==========================================
	// Elaboration check
	initial begin
		if (DUAL_DISPLAY !== 1'b0 && DUAL_DISPLAY !== 1'b1) begin
			$error("DUAL_DISPLAY must be 0 or 1");
		end
	end

	logic [7:0] next_status;
	logic       wipe;
	logic       poll_done;
	logic       poll_clear;
	logic       set_meas;
	srs_pkg::srs_poll_t poll_state;

	// [R1] Full wipe
	assign wipe = ev_clr.dev_clear | ev_clr.cmd_clear;
	// Poll completes at the byte delivery cycle
	assign poll_done = (poll_state == srs_pkg::SRS_POLL_ACTIVE);

	// ==========================================
	// Per-bit strobes
	// [R4] [R5] [R6] A poll seen by the bus interface clears like our own poll
	assign poll_clear = poll_done | ev_clr.serial_poll;
	// [R13] [R14] [R16] These requests report with the measurement-end bit set,
	// so each one alone on a clear byte gives 69, 73 or 193 rather than a bare bit
	assign set_meas = ev_set.meas_end | ev_set.comp_hilo | ev_set.smooth1_full |
	                  ev_set.cal_enter;

	// ==========================================
	// Next status byte; sets win over per-bit clears
	always_comb begin
		next_status = status_byte;
		// [R2] Measurement end clear
		if (ev_clr.data_sent | ev_clr.setup_change | ev_clr.trigger) begin
			next_status[srs_pkg::BIT_MEAS_END] = 1'b0;
		end
		// [R3] Syntax error clear
		if (ev_clr.remote_cmd) begin
			next_status[srs_pkg::BIT_SYNTAX] = 1'b0;
		end
		// [R4] Comparator clear
		if (ev_clr.comp_off | poll_clear) begin
			next_status[srs_pkg::BIT_COMP] = 1'b0;
		end
		// [R5] First smoothing clear
		if (ev_clr.smooth_off | poll_clear | ev_clr.setup_change |
		    ev_clr.smooth_count_change) begin
			next_status[srs_pkg::BIT_SMOOTH1] = 1'b0;
		end
		// [R6] Second smoothing clear
		if (ev_clr.disp2_off | ev_clr.smooth_off | poll_clear |
		    ev_clr.setup_change | ev_clr.smooth_count_change) begin
			next_status[srs_pkg::BIT_SMOOTH2] = 1'b0;
		end
		// [R8] Calibration clear
		if (ev_clr.cal_cancel) begin
			next_status[srs_pkg::BIT_CAL] = 1'b0;
		end
		// [R9] [R12] Measurement end, held until data is sent
		if (set_meas) begin
			next_status[srs_pkg::BIT_MEAS_END] = 1'b1;
		end
		// [R11] [R12] Syntax error
		if (ev_set.syntax_err) begin
			next_status[srs_pkg::BIT_SYNTAX] = 1'b1;
		end
		// [R13] Comparator HI or LO
		if (ev_set.comp_hilo) begin
			next_status[srs_pkg::BIT_COMP] = 1'b1;
		end
		// [R14] First smoothing full
		if (ev_set.smooth1_full) begin
			next_status[srs_pkg::BIT_SMOOTH1] = 1'b1;
		end
		// [R15] Second smoothing full, dual-display only
		if (ev_set.smooth2_full && DUAL_DISPLAY) begin
			next_status[srs_pkg::BIT_SMOOTH2] = 1'b1;
		end
		// [R16] Calibration entry
		if (ev_set.cal_enter) begin
			next_status[srs_pkg::BIT_CAL] = 1'b1;
		end
		// [R7] Fixed zero and summary bit
		next_status[srs_pkg::BIT_ZERO] = 1'b0;
		next_status[srs_pkg::BIT_RQS] = |(next_status & srs_pkg::SUMMARY_MASK);
	end

	// ==========================================
	// Status register
	always_ff @(posedge clk_sys) begin
		// [R1] Power-on and clear commands
		if (!resetn || wipe) begin
			status_byte <= srs_pkg::STATUS_RESET;
		end else begin
			status_byte <= next_status;
		end
	end

	// ==========================================
	// Serial poll: answer one cycle after the request
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			poll_state <= srs_pkg::SRS_POLL_IDLE;
		end else begin
			case (poll_state)
				srs_pkg::SRS_POLL_IDLE: begin
					if (poll_req) begin
						poll_state <= srs_pkg::SRS_POLL_ACTIVE;
					end
				end
				srs_pkg::SRS_POLL_ACTIVE: begin
					poll_state <= srs_pkg::SRS_POLL_IDLE;
				end
				default: begin
					poll_state <= srs_pkg::SRS_POLL_IDLE;
				end
			endcase
		end
	end

	// [R10] Poll answer carries the current byte
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			poll_valid <= 1'b0;
			poll_byte  <= srs_pkg::STATUS_RESET;
		end else begin
			poll_valid <= poll_req && (poll_state == srs_pkg::SRS_POLL_IDLE);
			if (poll_req && (poll_state == srs_pkg::SRS_POLL_IDLE)) begin
				poll_byte <= status_byte;
			end
		end
	end

	// ==========================================
	// Request line; open-drain so it is driven only when asserted
	always_ff @(posedge clk_sys) begin
		if (!resetn || wipe) begin
			srq_out <= 1'b0;
			srq_oe  <= 1'b0;
		end else begin
			// [R17] [R18] Enabled mode follows the summary bit
			srq_out <= 1'b0;
			srq_oe  <= next_status[srs_pkg::BIT_RQS] && !srq_off_mode;
		end
	end

	// ==========================================
	// Checks

	bit_five_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R7]
		!status_byte[srs_pkg::BIT_ZERO])
		else $error("bit five set");

	summary_track_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R7]
		status_byte[srs_pkg::BIT_RQS] == |(status_byte & srs_pkg::SUMMARY_MASK))
		else $error("summary bit wrong");

	wipe_clears_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R1]
		wipe |=> status_byte == srs_pkg::STATUS_RESET && !srq_oe)
		else $error("wipe did not clear");

	meas_end_set_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R9]
		(ev_set.meas_end && !wipe && status_byte == 8'h00 && ev_set[4:0] == 5'h00)
		|=> status_byte == 8'h41)
		else $error("measurement end not 65");

	meas_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R2]
		((ev_clr.data_sent || ev_clr.setup_change || ev_clr.trigger) && !set_meas)
		|=> !status_byte[srs_pkg::BIT_MEAS_END])
		else $error("measurement end not cleared");

	syntax_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R3]
		(ev_clr.remote_cmd && !ev_set.syntax_err)
		|=> !status_byte[srs_pkg::BIT_SYNTAX])
		else $error("syntax bit not cleared");

	syntax_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R11]
		(status_byte[srs_pkg::BIT_SYNTAX] && !wipe && !ev_clr.remote_cmd)
		|=> status_byte[srs_pkg::BIT_SYNTAX])
		else $error("syntax bit lost");

	comp_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R4]
		((ev_clr.comp_off || ev_clr.serial_poll) && !ev_set.comp_hilo)
		|=> !status_byte[srs_pkg::BIT_COMP])
		else $error("comparator bit not cleared");

	comp_set_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R13]
		(!wipe && status_byte == 8'h00 && ev_set[4:0] == 5'h08)
		|=> status_byte == 8'h45)
		else $error("comparator not 69");

	smooth1_set_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R14]
		(!wipe && status_byte == 8'h00 && ev_set[4:0] == 5'h04)
		|=> status_byte == 8'h49)
		else $error("smoothing full not 73");

	smooth1_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R5]
		((ev_clr.smooth_off || ev_clr.setup_change || ev_clr.smooth_count_change ||
		  poll_done) && !ev_set.smooth1_full)
		|=> !status_byte[srs_pkg::BIT_SMOOTH1])
		else $error("first smoothing bit not cleared");

	smooth2_set_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R15]
		(ev_set.smooth2_full && DUAL_DISPLAY && !wipe)
		|=> status_byte[srs_pkg::BIT_SMOOTH2] && status_byte[srs_pkg::BIT_RQS])
		else $error("second smoothing bit not set");

	smooth2_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R6]
		((ev_clr.disp2_off || ev_clr.smooth_off || ev_clr.setup_change ||
		  ev_clr.smooth_count_change || poll_done) && !ev_set.smooth2_full)
		|=> !status_byte[srs_pkg::BIT_SMOOTH2])
		else $error("second smoothing bit not cleared");

	cal_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R8]
		(ev_clr.cal_cancel && !ev_set.cal_enter)
		|=> !status_byte[srs_pkg::BIT_CAL])
		else $error("calibration bit not cleared");

	cal_value_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R16]
		(!wipe && status_byte == 8'h00 && ev_set[4:0] == 5'h01)
		|=> status_byte == 8'hC1)
		else $error("calibration not 193");
	both_set_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R12]
		(ev_set.meas_end && ev_set.syntax_err && !wipe && status_byte == 8'h00 &&
		 ev_set[3:0] == 4'h0) |=> status_byte == 8'h43)
		else $error("combined not 67");

	cal_set_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R16]
		(ev_set.cal_enter && !wipe) |=> status_byte[srs_pkg::BIT_CAL] &&
		status_byte[srs_pkg::BIT_RQS])
		else $error("calibration bit not set");

	meas_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R2]
		(status_byte[0] && !wipe && !ev_clr.data_sent && !ev_clr.setup_change &&
		 !ev_clr.trigger) |=> status_byte[0])
		else $error("measurement end lost");

	comp_poll_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R4]
		(poll_done && !ev_set.comp_hilo) |=> !status_byte[srs_pkg::BIT_COMP])
		else $error("poll did not clear comparator");

	poll_answer_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R10]
		(poll_req && poll_state == srs_pkg::SRS_POLL_IDLE) |=>
		poll_valid && poll_byte == $past(status_byte))
		else $error("poll answer wrong");

	poll_refuse_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R10]
		(poll_state == srs_pkg::SRS_POLL_ACTIVE || !poll_req) |=> !poll_valid)
		else $error("poll answered twice");

	poll_keep_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R10]
		!(poll_req && poll_state == srs_pkg::SRS_POLL_IDLE) |=> $stable(poll_byte))
		else $error("poll byte changed");

	srq_off_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R17]
		srq_off_mode |=> !srq_oe)
		else $error("request in off mode");

	srq_data_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R18]
		!srq_out)
		else $error("request data driven high");

	srq_follow_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [R18]
		(!srq_off_mode && !wipe) |=> srq_oe == status_byte[srs_pkg::BIT_RQS])
		else $error("request line mismatch");

endmodule : srs_status

// ===== tb/srs_poll_ctrl.sv
// Bus controller model that serial polls the device
`timescale 1ns/10ps
module srs_poll_ctrl (
	// Clock
	input  wire logic       clk_sys,
	// Poll handshake
	input  wire logic       poll_valid,
	input  wire logic [7:0] poll_byte,
	output logic            poll_req
);
	initial poll_req = 1'b0;
	// Serial poll read
	// Holds one idle cycle after the poll so polls keep their spacing
	task automatic do_poll(output logic [7:0] b, output bit ok);
		@(posedge clk_sys) #1;
		poll_req = 1'b1;
		@(posedge clk_sys) #1;
		poll_req = 1'b0;
		ok = (poll_valid === 1'b1);
		b = poll_byte;
		@(posedge clk_sys);
	endtask : do_poll
endmodule : srs_poll_ctrl

// ===== tb/tb.sv
// Self-checking bench for the service-request status byte
`timescale 1ns/10ps
module tb;
	typedef struct packed {
		logic [5:0]  s;
		logic [11:0] c;
		logic [7:0]  e;
	} srs_row_t;
	logic              clk_sys = 1'b0;
	logic              resetn = 1'b0;
	srs_pkg::srs_set_t ev_set = '0;
	srs_pkg::srs_clr_t ev_clr = '0;
	logic              srq_off_mode = 1'b0;
	logic              poll_req;
	logic              poll_valid;
	logic              srq_out;
	logic              srq_oe;
	logic [7:0]        poll_byte;
	logic [7:0]        status_byte;
	logic [7:0]        b;
	bit                ok;
	int                fail_count = 0;
	int                cmp_count = 0;
	int                cyc = 0;
	srs_row_t          rows[18];

	always #2.5 clk_sys = ~clk_sys;

	srs_status #(.DUAL_DISPLAY(1'b1)) dut (
		.clk_sys(clk_sys), .resetn(resetn), .ev_set(ev_set), .ev_clr(ev_clr),
		.srq_off_mode(srq_off_mode), .poll_req(poll_req), .poll_valid(poll_valid),
		.poll_byte(poll_byte), .srq_out(srq_out), .srq_oe(srq_oe),
		.status_byte(status_byte));

	srs_poll_ctrl u_ctrl (.clk_sys(clk_sys), .poll_valid(poll_valid),
		.poll_byte(poll_byte), .poll_req(poll_req));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic pulse(input logic [5:0] s, input logic [11:0] c);
		@(posedge clk_sys) #1;
		ev_set = s;
		ev_clr = c;
		@(posedge clk_sys) #1;
		ev_set = '0;
		ev_clr = '0;
	endtask : pulse

	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test

	// ==========================================
	// Timeout: whole run is about 70 cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 2000) begin
			fail_count++;
			end_of_test();
		end
	end

	// ==========================================
	// Main sequence
	initial begin
		rows = '{'{6'h20, 12'h000, 8'h41}, '{6'h00, 12'h200, 8'h00},
			'{6'h30, 12'h000, 8'h43}, '{6'h00, 12'h100, 8'h42},
			'{6'h00, 12'h040, 8'h00}, '{6'h08, 12'h000, 8'h45},
			'{6'h00, 12'h220, 8'h00}, '{6'h04, 12'h000, 8'h49},
			'{6'h00, 12'h208, 8'h00}, '{6'h02, 12'h000, 8'h50},
			'{6'h00, 12'h004, 8'h00}, '{6'h01, 12'h000, 8'hC1},
			'{6'h00, 12'h001, 8'h41}, '{6'h02, 12'h080, 8'h50},
			'{6'h00, 12'h010, 8'h00}, '{6'h0C, 12'h000, 8'h4D},
			'{6'h00, 12'h400, 8'h00}, '{6'h20, 12'h800, 8'h00}};
		repeat (20) @(posedge clk_sys);
		chk(status_byte, 8'h00);
		#1 resetn = 1'b1;
		foreach (rows[i]) begin
			pulse(rows[i].s, rows[i].c);
			chk(status_byte, rows[i].e);
			chk({srq_out, srq_oe}, {1'b0, rows[i].e[6]});
		end
		$display("table rows done");
		// Poll answers with the byte, then drops the per-poll bits
		pulse(6'h2C, 12'h000);
		u_ctrl.do_poll(b, ok);
		chk({7'h00, ok}, 8'h01);
		chk(b, 8'h4D);
		#1 chk(status_byte, 8'h41);
		$display("poll test done");
		srq_off_mode = 1'b1;
		pulse(6'h10, 12'h000);
		chk({status_byte[7:1], srq_oe}, 8'h42);
		u_ctrl.do_poll(b, ok);
		chk(b, 8'h43);
		$display("request-off test done");
		#1 resetn = 1'b0;
		@(posedge clk_sys) #1;
		chk(status_byte, 8'h00);
		chk({poll_valid, srq_oe}, 2'b00);
		$display("reset test done");
		end_of_test();
	end
endmodule : tb
